// ==== design/mode_regs_pkg.sv ====
// Shared constants and types for the mode-register bank (I/O config,
// temperature, maker identity and first revision registers).
// Assumes the core clock and the link clock are unrelated in phase.
package mode_regs_pkg;

	// Mode register addresses
	localparam logic [5:0] ADDR_IO_CFG = 6'h03;
	localparam logic [5:0] ADDR_TEMP = 6'h04;
	localparam logic [5:0] ADDR_MAKER = 6'h05;
	localparam logic [5:0] ADDR_REV_ONE = 6'h06;

	// I/O configuration field positions
	localparam int IO_PULLUP_CAL_POINT_BIT = 0;
	localparam int IO_WRITE_POSTAMBLE_LEN_BIT = 1;
	localparam int IO_PROTECT_BIT = 2;
	localparam int IO_PULLDOWN_DRIVE_STRENGTH_LSB = 3;
	localparam int IO_READ_BUS_INVERSION_EN_BIT = 6;
	localparam int IO_WRITE_BUS_INVERSION_EN_BIT = 7;

	// Temperature register field positions
	localparam int TEMP_RATE_LSB = 0;
	localparam int TEMP_SRA_BIT = 3;
	localparam int TEMP_ENTRY_BIT = 4;
	localparam int TEMP_OFFSET_LSB = 5;
	localparam int TEMP_TUF_BIT = 7;

	// Refresh-rate codes
	localparam logic [2:0] RATE_LOW_LIMIT = 3'h0;
	localparam logic [2:0] RATE_ONE_X = 3'h3;
	localparam logic [2:0] RATE_DERATE = 3'h6;
	localparam logic [2:0] RATE_HIGH_LIMIT = 3'h7;
	localparam int RATE_HOT_BIT = 2;

	// Reset values
	localparam logic [7:0] IO_CFG_RESET = 8'h31;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// One mode-register command carried across the link
	typedef struct packed {
		logic wr;
		logic [5:0] addr;
		logic [7:0] data;
	} mr_cmd_t;

	// I/O configuration word, one copy per set point
	typedef struct packed {
		logic write_bus_inversion_en;
		logic read_bus_inversion_en;
		logic [2:0] pulldown_drive_strength;
		logic protect;
		logic write_postamble_len;
		logic pullup_cal_point;
	} io_cfg_t;

endpackage

// ==== design/sdram_mode_regs_io_temp.sv ====
// Mode-register bank: I/O configuration (two set-point copies),
// temperature status/control, maker identity and first revision.
// Commands arrive on the link clock; the bank lives on the core clock.
// Assumes the set-point selectors and the temperature sensor code come
// from logic on the core clock.
//
// How it works
// (RULE_01) Bit 0 picks pull-up calibration point
// (RULE_02) Bit 1 picks short or long postamble
// (RULE_03) Bit 2 enables repair protection, default off
// (RULE_04) Protection bit sticky until power-on reset
// (RULE_05) Protection blocks writing repair entry to one
// (RULE_06) Bits 5:3 pick pull-down strength, default six
// (RULE_07) Bits 6,7 enable read/write bus inversion
// (RULE_08) Writes and reads reach write-selected copy
// (RULE_09) Device runs from operating-selected copy only; repair protection here is taken from either copy
// (RULE_10) Temperature register reports refresh rate code
// (RULE_11) Rate bit 2 means hotter than 85C
// (RULE_12) Derating need reported as code 110b
// (RULE_13) Controller distrusts device at limit codes
// (RULE_14) Bit 3 controls self-refresh abort
// (RULE_15) Bit 4 enters or exits repair mode
// (RULE_16) Bits 6:5 hold controller thermal offset
// (RULE_17) Update flag sets on change, read clears
// (RULE_18) Flag zero at reset; rate valid after init
// (RULE_19) Temperature writes touch only bits 6:3
// (RULE_20) Address 05h reads maker identity code
// (RULE_21) Address 06h reads first revision code
// (RULE_22) I/O configuration sits at address 03h
// (RULE_23) Controller never writes reserved field codes
`timescale 1ns/1ps

module sdram_mode_regs_io_temp #(
	parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
	parameter logic [7:0] REV_ID_ONE = 8'h01 // Arbitrary value
) (
	// Core clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Link command port
	input wire logic link_clock,
	input wire logic cmd_valid,
	input wire mode_regs_pkg::mr_cmd_t cmd,
	output logic cmd_busy,
	output logic rd_valid,
	output logic [7:0] rd_data,
	// Set-point selectors and temperature sensor
	input wire logic write_set_point_sel,
	input wire logic operating_set_point_sel,
	input wire logic [2:0] sensor_rate,
	input wire logic init_done,
	// Active settings to the device
	output mode_regs_pkg::io_cfg_t active_cfg,
	output logic repair_protect,
	output logic repair_entry,
	output logic self_refresh_abort,
	output logic [1:0] thermal_offset,
	output logic [2:0] refresh_rate,
	output logic temp_over_85,
	output logic derate_needed,
	output logic temp_limit_hit
);
	import mode_regs_pkg::*;

	// ---------------- Link domain ----------------
	logic link_rst_meta;
	logic link_rst_reg;
	logic busy_reg;
	logic req_tgl_reg;
	mr_cmd_t hold_cmd_reg;
	logic ack_meta;
	logic ack_sync;
	logic ack_last;
	logic rd_valid_reg;
	logic [7:0] rd_data_reg;
	wire cmd_take;
	wire ack_edge;

	// ---------------- Core domain ----------------
	logic req_meta;
	logic req_sync;
	logic req_last;
	logic ack_tgl_reg;
	logic [7:0] resp_data_reg;
	io_cfg_t io_copy_reg [2];
	io_cfg_t active_cfg_reg;
	logic [2:0] rate_reg;
	logic tuf_reg;
	logic sra_reg;
	logic entry_reg;
	logic [1:0] offset_reg;
	logic init_seen_reg;
	logic hot_reg;
	logic derate_reg;
	logic limit_reg;
	logic protect_reg;
	wire req_edge;
	wire do_write;
	wire do_read;
	wire wr_io;
	wire wr_temp;
	wire rd_temp;
	wire protect_any;
	wire entry_next;
	wire rate_change;
	wire [2:0] rate_next;
	wire [7:0] temp_word;
	wire [7:0] read_word;
	io_cfg_t io_wr_word;

	// Link reset follows the core reset through two flops
	always_ff @(posedge link_clock) begin
		link_rst_meta <= sys_rst;
		link_rst_reg <= link_rst_meta;
	end

	// Command taken only while no earlier one is in flight
	assign cmd_take = cmd_valid & ~busy_reg;
	assign ack_edge = ack_sync ^ ack_last;

	// Hold the command steady and toggle the request
	always_ff @(posedge link_clock) begin
		if (link_rst_reg) begin
			busy_reg <= 1'b0;
			req_tgl_reg <= 1'b0;
			hold_cmd_reg <= '0;
		end else if (cmd_take) begin
			busy_reg <= 1'b1;
			req_tgl_reg <= ~req_tgl_reg;
			hold_cmd_reg <= cmd;
		end else if (ack_edge) begin
			busy_reg <= 1'b0;
		end
	end

	// Acknowledge toggle brought back into the link domain
	always_ff @(posedge link_clock) begin
		if (link_rst_reg) begin
			ack_meta <= 1'b0;
			ack_sync <= 1'b0;
			ack_last <= 1'b0;
		end else begin
			ack_meta <= ack_tgl_reg;
			ack_sync <= ack_meta;
			ack_last <= ack_sync;
		end
	end

	// Read answer: one-cycle strobe with the word the core prepared
	always_ff @(posedge link_clock) begin
		if (link_rst_reg) begin
			rd_valid_reg <= 1'b0;
			rd_data_reg <= 8'h00;
		end else begin
			rd_valid_reg <= ack_edge & ~hold_cmd_reg.wr;
			if (ack_edge & ~hold_cmd_reg.wr)
				rd_data_reg <= resp_data_reg;
		end
	end

	assign cmd_busy = busy_reg;
	assign rd_valid = rd_valid_reg;
	assign rd_data = rd_data_reg;

	// Request toggle brought into the core domain
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			req_meta <= 1'b0;
			req_sync <= 1'b0;
			req_last <= 1'b0;
		end else begin
			req_meta <= req_tgl_reg;
			req_sync <= req_meta;
			req_last <= req_sync;
		end
	end

	// Command decode; the held command is stable once the toggle lands
	assign req_edge = req_sync ^ req_last;
	assign do_write = req_edge & hold_cmd_reg.wr;
	assign do_read = req_edge & ~hold_cmd_reg.wr;
	assign wr_io = do_write & (hold_cmd_reg.addr == ADDR_IO_CFG); // [RULE_22]
	assign wr_temp = do_write & (hold_cmd_reg.addr == ADDR_TEMP); // [RULE_10]
	assign rd_temp = do_read & (hold_cmd_reg.addr == ADDR_TEMP);

	// Protection from either copy; once set the bit is kept
	assign protect_any = io_copy_reg[0].protect | io_copy_reg[1].protect;
	always_comb begin
		io_wr_word = io_cfg_t'(hold_cmd_reg.data); // [RULE_01] [RULE_02]
		io_wr_word.protect = hold_cmd_reg.data[IO_PROTECT_BIT] |
			io_copy_reg[write_set_point_sel].protect; // [RULE_03] [RULE_04]
	end

	// Repair entry: a one is refused while protection is on
	assign entry_next = (hold_cmd_reg.data[TEMP_ENTRY_BIT] & protect_any) ?
		entry_reg : hold_cmd_reg.data[TEMP_ENTRY_BIT]; // [RULE_05] [RULE_15]

	// Sensor code counts only after init; before it, the default rate
	assign rate_next = init_seen_reg ? sensor_rate : RATE_ONE_X; // [RULE_18]
	assign rate_change = rate_next != rate_reg;

	// Read multiplexer over the four registers
	assign temp_word = {tuf_reg, offset_reg, entry_reg, sra_reg, rate_reg};
	assign read_word =
		(hold_cmd_reg.addr == ADDR_IO_CFG) ?
			8'(io_copy_reg[write_set_point_sel]) : // [RULE_08]
		(hold_cmd_reg.addr == ADDR_TEMP) ? temp_word :
		(hold_cmd_reg.addr == ADDR_MAKER) ? MAKER_ID : // [RULE_20]
		(hold_cmd_reg.addr == ADDR_REV_ONE) ? REV_ID_ONE : // [RULE_21]
		UNMAPPED_READ;

	// I/O configuration copies: only the write-selected one is written
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			io_copy_reg[0] <= io_cfg_t'(IO_CFG_RESET); // [RULE_06] [RULE_07]
			io_copy_reg[1] <= io_cfg_t'(IO_CFG_RESET);
		end else if (wr_io) begin
			io_copy_reg[write_set_point_sel] <= io_wr_word; // [RULE_08]
		end
	end

	// Device runs from the operating copy only
	always_ff @(posedge clock) begin
		if (sys_rst)
			active_cfg_reg <= io_cfg_t'(IO_CFG_RESET);
		else
			active_cfg_reg <= io_copy_reg[operating_set_point_sel]; // [RULE_09]
	end

	// Writable temperature bits 6:3; the rest of the write is dropped
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sra_reg <= 1'b0;
			entry_reg <= 1'b0;
			offset_reg <= 2'b00;
		end else if (wr_temp) begin
			sra_reg <= hold_cmd_reg.data[TEMP_SRA_BIT]; // [RULE_14] [RULE_19]
			entry_reg <= entry_next;
			offset_reg <= hold_cmd_reg.data[TEMP_OFFSET_LSB +: 2]; // [RULE_16]
		end
	end

	// Refresh rate tracking and the update flag; a change beats a read
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			init_seen_reg <= 1'b0;
			rate_reg <= RATE_ONE_X;
			tuf_reg <= 1'b0; // [RULE_18]
		end else begin
			init_seen_reg <= init_seen_reg | init_done;
			rate_reg <= rate_next; // [RULE_10] [RULE_12]
			if (rate_change)
				tuf_reg <= 1'b1; // [RULE_17]
			else if (rd_temp)
				tuf_reg <= 1'b0;
		end
	end

	// Decoded temperature flags and the registered protection state
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			protect_reg <= 1'b0;
			hot_reg <= 1'b0;
			derate_reg <= 1'b0;
			limit_reg <= 1'b0;
		end else begin
			hot_reg <= rate_reg[RATE_HOT_BIT]; // [RULE_11]
			derate_reg <= rate_reg == RATE_DERATE; // [RULE_12]
			limit_reg <= (rate_reg == RATE_LOW_LIMIT) |
				(rate_reg == RATE_HIGH_LIMIT); // [RULE_13]
			protect_reg <= protect_any; // [RULE_04]
		end
	end

	// Answer every command with a toggle; reads load the response word
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ack_tgl_reg <= 1'b0;
			resp_data_reg <= 8'h00;
		end else if (req_edge) begin
			ack_tgl_reg <= ~ack_tgl_reg;
			if (do_read)
				resp_data_reg <= read_word;
		end
	end

	// Outputs
	assign active_cfg = active_cfg_reg;
	assign repair_protect = protect_reg;
	assign repair_entry = entry_reg;
	assign self_refresh_abort = sra_reg;
	assign thermal_offset = offset_reg;
	assign refresh_rate = rate_reg;
	assign temp_over_85 = hot_reg;
	assign derate_needed = derate_reg;
	assign temp_limit_hit = limit_reg;

	// ---------------- Checks ----------------
	localparam int ANS_MIN = 3;
	localparam int ANS_MAX = 40;
	sequence s_read_taken;
		cmd_take & ~cmd.wr;
	endsequence

	sequence s_answer;
		##[ANS_MIN:ANS_MAX] rd_valid_reg;
	endsequence

	chk_read_answer: assert property ( // [RULE_10]
		@(posedge link_clock) disable iff (link_rst_reg)
		s_read_taken |-> s_answer)
		else $error("read command not answered in time");

	chk_protect_sticky: assert property ( // [RULE_04]
		@(posedge clock) disable iff (sys_rst)
		protect_any |=> protect_any)
		else $error("repair protection cleared without reset");

	chk_entry_blocked: assert property ( // [RULE_05]
		@(posedge clock) disable iff (sys_rst)
		wr_temp & protect_any & ~entry_reg |=> ~entry_reg [*2])
		else $error("repair entry accepted while protected");

	chk_copy_select: assert property ( // [RULE_08]
		@(posedge clock) disable iff (sys_rst)
		wr_io & ~write_set_point_sel & ~io_copy_reg[1].protect |=>
			io_copy_reg[0].pulldown_drive_strength == $past(hold_cmd_reg.data[5:3]) &&
			$stable(io_copy_reg[1]))
		else $error("write reached wrong set-point copy");

	chk_active_copy: assert property ( // [RULE_09]
		@(posedge clock) disable iff (sys_rst)
		~wr_io ##1 ~wr_io && $stable(operating_set_point_sel) |->
			active_cfg_reg == io_copy_reg[operating_set_point_sel])
		else $error("device not running from operating copy");

	chk_flag_set: assert property ( // [RULE_17]
		@(posedge clock) disable iff (sys_rst)
		rate_change |=> tuf_reg && rate_reg != $past(rate_reg))
		else $error("update flag missed a rate change");

	chk_flag_clear: assert property ( // [RULE_17]
		@(posedge clock) disable iff (sys_rst)
		rd_temp & ~rate_change |=> ~tuf_reg)
		else $error("update flag not cleared by read");

	chk_rate_init: assert property ( // [RULE_18]
		@(posedge clock) disable iff (sys_rst)
		~init_seen_reg |=> rate_reg == RATE_ONE_X)
		else $error("rate changed before initialization");

	chk_temp_write: assert property ( // [RULE_19]
		@(posedge clock) disable iff (sys_rst)
		wr_temp |=> sra_reg == $past(hold_cmd_reg.data[3]) &&
			offset_reg == $past(hold_cmd_reg.data[6:5]) &&
			tuf_reg == ($past(tuf_reg) | $past(rate_change)))
		else $error("temperature write touched wrong bits");

	chk_maker_read: assert property ( // [RULE_20]
		@(posedge clock) disable iff (sys_rst)
		do_read && hold_cmd_reg.addr == ADDR_MAKER |=>
			resp_data_reg == MAKER_ID)
		else $error("maker identity read wrong");

	chk_derate_flag: assert property ( // [RULE_12]
		@(posedge clock) disable iff (sys_rst)
		rate_reg == RATE_DERATE |=> derate_reg && hot_reg)
		else $error("derating code not flagged");

endmodule

// ==== tb/mode_cmd_host.sv ====
// Host controller model: issues mode-register writes and reads.
// Assumes the bank takes a command at a link edge while busy is low.
`timescale 1ns/1ps

module mode_cmd_host (
	// Link side
	input wire logic link_clock,
	input wire logic cmd_busy,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	output logic cmd_valid,
	output mode_regs_pkg::mr_cmd_t cmd
);
	import mode_regs_pkg::*;

	// Idle bus until the first command
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
	end

	// Hold the request through the taking edge, then show a changed word
	// Callers keep reserved field codes out of data
	// Callers do not trust the device on limit-code rates
	task automatic xfer(input logic wr, input logic [5:0] addr,
		input logic [7:0] data, output logic [7:0] rdata, output logic ok);
		int n;
		rdata = 8'hxx;
		ok = 1'b0;
		@(negedge link_clock);
		cmd = '{wr: wr, addr: addr, data: data};
		cmd_valid = 1'b1;
		@(negedge link_clock);
		cmd_valid = 1'b0;
		cmd = ~cmd;
		for (n = 0; n < 24 && !ok; n++) begin
			if (rd_valid === 1'b1)
				rdata = rd_data;
			if (cmd_busy === 1'b0)
				ok = 1'b1;
			else
				@(negedge link_clock);
		end
	endtask
endmodule

// ==== tb/test_sdram_mode_regs_io_temp.sv ====
// Self-checking bench for the mode-register bank.
// Assumes the host model drives the link command port.
`timescale 1ns/1ps

module test_sdram_mode_regs_io_temp;
	import mode_regs_pkg::*;

	localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
	localparam logic [7:0] REV = 8'h27; // Arbitrary value
	logic clock, link_clock, sys_rst, cmd_valid, cmd_busy, rd_valid;
	logic write_set_point_sel, operating_set_point_sel, init_done;
	logic repair_protect, repair_entry, self_refresh_abort;
	logic temp_over_85, derate_needed, temp_limit_hit;
	logic [7:0] rd_data;
	logic [2:0] sensor_rate, refresh_rate;
	logic [1:0] thermal_offset;
	mr_cmd_t cmd;
	io_cfg_t active_cfg;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;

	// Core and link clocks, unrelated in phase
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		link_clock = 1'b0;
		#3.3;
		forever #80 link_clock = ~link_clock;
	end

	sdram_mode_regs_io_temp #(.MAKER_ID(MAKER), .REV_ID_ONE(REV)) dut (
		.clock(clock), .sys_rst(sys_rst), .link_clock(link_clock),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_busy(cmd_busy),
		.rd_valid(rd_valid), .rd_data(rd_data),
		.write_set_point_sel(write_set_point_sel),
		.operating_set_point_sel(operating_set_point_sel),
		.sensor_rate(sensor_rate), .init_done(init_done),
		.active_cfg(active_cfg), .repair_protect(repair_protect),
		.repair_entry(repair_entry), .self_refresh_abort(self_refresh_abort),
		.thermal_offset(thermal_offset), .refresh_rate(refresh_rate),
		.temp_over_85(temp_over_85), .derate_needed(derate_needed),
		.temp_limit_hit(temp_limit_hit));

	mode_cmd_host host (
		.link_clock(link_clock), .cmd_busy(cmd_busy), .rd_valid(rd_valid),
		.rd_data(rd_data), .cmd_valid(cmd_valid), .cmd(cmd));

	// Hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fail_count++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic mrw(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic ok;
		host.xfer(1'b1, a, d, r, ok);
		chk("write done", 8'h01, {7'h0, ok});
		repeat (4) @(negedge clock);
	endtask

	task automatic mrr(input logic [5:0] a, input logic [7:0] e, string n);
		logic [7:0] r;
		logic ok;
		host.xfer(1'b0, a, 8'h00, r, ok);
		chk(n, e, r);
	endtask

	// Reset long enough for both domains
	task automatic do_reset();
		@(negedge clock);
		sys_rst = 1'b1;
		repeat (16) @(negedge clock);
		repeat (4) @(posedge link_clock);
		@(negedge clock);
		sys_rst = 1'b0;
		repeat (4) @(posedge link_clock);
	endtask

	task automatic s_reset();
		chk("active_cfg", IO_CFG_RESET, active_cfg);
		chk("rate", 8'h03, {5'h0, refresh_rate});
		chk("temp outs", 8'h00, {5'h0, repair_entry, thermal_offset});
		chk("sra", 8'h00, {7'h0, self_refresh_abort});
		mrr(ADDR_TEMP, 8'h03, "temp");
		mrr(ADDR_IO_CFG, IO_CFG_RESET, "io reset");
		mrr(ADDR_MAKER, MAKER, "maker");
		mrr(ADDR_REV_ONE, REV, "rev");
		mrw(ADDR_MAKER, 8'h00);
		mrr(ADDR_MAKER, MAKER, "maker ro");
		mrr(6'h3f, UNMAPPED_READ, "unmapped");
	endtask

	task automatic s_setpt();
		mrw(ADDR_IO_CFG, 8'hcb);
		write_set_point_sel = 1'b1;
		mrw(ADDR_IO_CFG, 8'h12);
		mrr(ADDR_IO_CFG, 8'h12, "copy1");
		chk("op copy0", 8'hcb, active_cfg);
		@(negedge clock);
		operating_set_point_sel = 1'b1;
		write_set_point_sel = 1'b0;
		repeat (4) @(negedge clock);
		chk("op copy1", 8'h12, active_cfg);
		mrr(ADDR_IO_CFG, 8'hcb, "copy0");
	endtask

	task automatic s_temp();
		mrw(ADDR_TEMP, 8'hbf);
		mrr(ADDR_TEMP, 8'h3b, "temp wr");
		chk("temp outs", 8'h05, {5'h0, repair_entry, thermal_offset});
		chk("sra", 8'h01, {7'h0, self_refresh_abort});
		mrw(ADDR_TEMP, 8'h40);
		chk("temp outs", 8'h02, {5'h0, repair_entry, thermal_offset});
		chk("sra", 8'h00, {7'h0, self_refresh_abort});
	endtask

	task automatic s_rate();
		int i;
		@(negedge clock);
		init_done = 1'b1;
		for (i = 0; i < 8; i++) begin
			sensor_rate = i[2:0];
			repeat (4) @(negedge clock);
			chk("rate", {5'h0, i[2:0]}, {5'h0, refresh_rate});
			chk("flags", {5'h0, i[2], i == 6, i == 0 || i == 7},
				{5'h0, temp_over_85, derate_needed, temp_limit_hit});
		end
		sensor_rate = 3'h5;
		repeat (4) @(negedge clock);
		mrr(ADDR_TEMP, 8'hc5, "flag set");
		mrr(ADDR_TEMP, 8'h45, "flag clr");
	endtask

	task automatic s_protect();
		mrw(ADDR_IO_CFG, 8'h34);
		chk("protect", 8'h01, {7'h0, repair_protect});
		mrw(ADDR_TEMP, 8'h10);
		chk("entry", 8'h00, {7'h0, repair_entry});
		mrw(ADDR_IO_CFG, 8'h30);
		mrr(ADDR_IO_CFG, 8'h34, "sticky");
		do_reset();
		chk("protect", 8'h00, {7'h0, repair_protect});
	endtask

	// Main sequence
	initial begin
		sys_rst = 1'b1;
		write_set_point_sel = 1'b0;
		operating_set_point_sel = 1'b0;
		init_done = 1'b0;
		sensor_rate = 3'h3;
		do_reset();
		s_reset();
		s_setpt();
		s_temp();
		s_rate();
		s_protect();
		results();
	end
endmodule
